// ---- design/adb_pkg.sv ----
// constants, field positions and types for the amplifier register bank
// assumes a 50 MHz system clock sampling the two-wire bus pins
package adb_pkg;
	localparam logic [6:0] CHIP_ADDR = 7'h6C;
	localparam int NUM_CH = 4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [1:0] WR_BYTES = 2'h2;
	localparam logic [1:0] RD_LAST = 2'h3;
	localparam int DIR_BIT = 0;
	localparam int MSB = 7;
	// control byte one
	localparam int C1_DIAG_EN = 6;
	localparam int C1_OFS_EN = 5;
	localparam int C1_FRONT_GAIN = 4;
	localparam int C1_REAR_GAIN = 3;
	localparam int C1_FRONT_UNMUTE = 2;
	localparam int C1_REAR_UNMUTE = 1;
	// control byte two
	localparam int C2_TEST_HI = 6;
	localparam int C2_TEST_LO = 5;
	localparam int C2_OPERATE = 4;
	localparam int C2_LINE_MODE = 3;
	// diagnostic bytes
	localparam int DB_THERMAL = 7;
	localparam int DB_CYCLE_DONE = 6;
	localparam int DB_OFS_ACT = 7;
	localparam int DB_STANDBY = 7;
	localparam int DB_DIAG = 6;
	localparam int DB_PERM = 4;
	localparam int DB_SHORT_LOAD = 3;
	localparam int DB_OPEN_OFS = 2;
	localparam int DB_SHORT_VS = 1;
	localparam int DB_SHORT_GND = 0;
	localparam logic [7:0] CTL1_RESET = 8'h00;
	localparam logic [7:0] CTL2_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	typedef logic [7:0] adb_byte_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_WR = 3'b011,
		ST_RD = 3'b100,
		ST_RD_ACK = 3'b101
	} adb_state_type;
endpackage

// ---- design/adb_chan_if.sv ----
// per-channel signals between the register bank and a channel reporter
// assumes all members are on the system clock
`timescale 1ns/100ps
interface adb_chan_if;
	logic offset_en;
	logic window_start;
	logic perm;
	logic short_load;
	logic open_load;
	logic offset_raw;
	logic short_vs;
	logic short_gnd;
	logic [4:0] report;
	modport core(input offset_en, window_start, perm, short_load, open_load,
		offset_raw, short_vs, short_gnd, output report);
	modport bank(output offset_en, window_start, perm, short_load, open_load,
		offset_raw, short_vs, short_gnd, input report);
endinterface

// ---- design/adb_chan_diag.sv ----
// one channel's low five report bits and its offset persistence tracker
// assumes fault inputs are already on the system clock
`timescale 1ns/100ps
module adb_chan_diag (
	input wire logic clock_in,
	input wire logic rst_in,
	adb_chan_if.core chan
);
	import adb_pkg::*;
	logic persist_reg;
	logic open_ofs;

	// offset must hold through the whole window
	always_ff @(posedge clock_in) begin
		if (rst_in)
			persist_reg <= 1'b0;
		else if (chan.window_start)
			persist_reg <= chan.offset_raw; // RULE24
		else if (!chan.offset_raw || !chan.offset_en)
			persist_reg <= 1'b0; // RULE24
	end

	assign open_ofs = (chan.perm || chan.offset_en) ? persist_reg :
		chan.open_load; // RULE20
	assign chan.report = {chan.perm, chan.short_load, open_ofs,
		chan.short_vs, chan.short_gnd}; // RULE18 RULE19 RULE21 RULE22

	property p_offset_drop;
		@(posedge clock_in) disable iff (rst_in)
		(!chan.window_start && !chan.offset_raw) |=> !persist_reg;
	endproperty
	a_offset_drop: assert property (p_offset_drop) // RULE24
		else $error("offset flag survived a gap in the window");

	property p_offset_hold;
		@(posedge clock_in) disable iff (rst_in)
		(chan.window_start && chan.offset_raw && chan.offset_en)
		##1 (chan.offset_raw && chan.offset_en && !chan.window_start)[*2]
		|-> persist_reg;
	endproperty
	a_offset_hold: assert property (p_offset_hold) // RULE24
		else $error("persistent offset not flagged");
endmodule

// ---- design/adb_reg_bank.sv ----
// two-wire bus slave register bank of a four-channel amplifier
// assumes scl/sda are open-drain pins sampled by the 50 MHz clock;
// fault inputs come from logic on the same clock
//
// How it works
// RULE1: answer only chip address 1101100
// RULE2: address bit zero picks write or read
// RULE3: host writes two control bytes in order
// RULE4: read returns four channel bytes in order
// RULE5: control one D6 enables permanent diagnostics
// RULE6: control one D5 enables offset detection
// RULE7: control one D4 picks front gain
// RULE8: control one D3 picks rear gain
// RULE9: control one D2 low mutes front
// RULE10: control one D1 low mutes rear
// RULE11: control two D4 low means standby
// RULE12: control two D3 picks line-driver mode
// RULE13: first byte D7 shows thermal warning
// RULE14: first byte D6 shows cycle terminated
// RULE15: second byte D7 shows offset detection on
// RULE16: third byte D7 mirrors standby control
// RULE17: third byte D6 mirrors diagnostic enable
// RULE18: D4 tells turn-on or permanent result
// RULE19: D3 flags a shorted load
// RULE20: D2 flags open load or offset
// RULE21: D1 flags short to supply
// RULE22: D0 flags short to ground
// RULE23: each read restarts cycles, returns previous
// RULE24: offset window runs between reads
// RULE25: settings change only after acknowledged byte
`timescale 1ns/100ps
module adb_reg_bank (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic thermal_warn_in,
	input wire logic cycle_done_in,
	input wire logic [adb_pkg::NUM_CH-1:0] perm_diag_in,
	input wire logic [adb_pkg::NUM_CH-1:0] short_load_in,
	input wire logic [adb_pkg::NUM_CH-1:0] open_load_in,
	input wire logic [adb_pkg::NUM_CH-1:0] offset_in,
	input wire logic [adb_pkg::NUM_CH-1:0] short_vs_in,
	input wire logic [adb_pkg::NUM_CH-1:0] short_gnd_in,
	output logic diag_enable_out,
	output logic offset_enable_out,
	output logic front_gain_12db_out,
	output logic rear_gain_12db_out,
	output logic front_unmute_out,
	output logic rear_unmute_out,
	output logic operate_out,
	output logic line_driver_mode_out,
	output logic [1:0] test_bits_out,
	output logic diag_restart_out
);
	import adb_pkg::*;

	logic scl_meta_reg, scl_sync_reg, scl_dly_reg;
	logic sda_meta_reg, sda_sync_reg, sda_dly_reg;
	adb_state_type state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	adb_byte_type shift_reg, shift_next;
	adb_byte_type tx_reg, tx_next;
	logic [1:0] idx_reg, idx_next;
	logic is_read_reg, is_read_next;
	logic data_ack_reg, data_ack_next;
	logic seen_reg, seen_next;
	logic oe_reg, oe_next;
	adb_byte_type ctl1_reg, ctl1_next;
	adb_byte_type ctl2_reg, ctl2_next;
	adb_byte_type snap_reg [NUM_CH];
	adb_byte_type snap_next [NUM_CH];
	adb_byte_type db [NUM_CH];
	logic [4:0] rep [NUM_CH];
	logic restart_reg;

	adb_chan_if ch_if [NUM_CH] ();

	// pin synchronisers; edge copies sit at idle high in reset
	always_ff @(posedge clock_in) begin
		scl_meta_reg <= scl_in;
		scl_sync_reg <= scl_meta_reg;
		scl_dly_reg <= scl_sync_reg || rst_in;
		sda_meta_reg <= sda_in;
		sda_sync_reg <= sda_meta_reg;
		sda_dly_reg <= sda_sync_reg || rst_in;
	end

	wire scl_rise = scl_sync_reg && !scl_dly_reg;
	wire scl_fall = !scl_sync_reg && scl_dly_reg;
	wire scl_high = scl_sync_reg && scl_dly_reg;
	wire start_cond = scl_high && sda_dly_reg && !sda_sync_reg;
	wire stop_cond = scl_high && !sda_dly_reg && sda_sync_reg;
	wire byte_done = scl_fall && (cnt_reg == BYTE_BITS);
	wire addr_hit = (shift_reg[MSB:1] == CHIP_ADDR); // RULE1
	wire wr_room = (idx_reg < WR_BYTES); // RULE3
	wire last_rd = (idx_reg == RD_LAST);
	wire ack_fall = (state_reg == ST_ACK) && scl_fall;
	wire commit = ack_fall && data_ack_reg; // RULE25
	wire commit1 = commit && (idx_reg == 2'h0);
	wire ofs_rise = commit1 && shift_reg[C1_OFS_EN] &&
		!ctl1_reg[C1_OFS_EN];
	wire read_done = stop_cond && seen_reg; // RULE23
	wire window_start = read_done || ofs_rise; // RULE24

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch
			assign ch_if[g].offset_en = ctl1_reg[C1_OFS_EN];
			assign ch_if[g].window_start = window_start;
			assign ch_if[g].perm = perm_diag_in[g];
			assign ch_if[g].short_load = short_load_in[g];
			assign ch_if[g].open_load = open_load_in[g];
			assign ch_if[g].offset_raw = offset_in[g];
			assign ch_if[g].short_vs = short_vs_in[g];
			assign ch_if[g].short_gnd = short_gnd_in[g];
			assign rep[g] = ch_if[g].report;
			adb_chan_diag u_chan (
				.clock_in(clock_in),
				.rst_in(rst_in),
				.chan(ch_if[g].core)
			);
		end
	endgenerate

	// top three bits differ per byte; low five are the channel report
	assign db[0] = {thermal_warn_in, cycle_done_in, 1'b0,
		rep[0]}; // RULE13 RULE14
	assign db[1] = {ctl1_reg[C1_OFS_EN], 2'b00, rep[1]}; // RULE15
	assign db[2] = {ctl2_reg[C2_OPERATE], ctl1_reg[C1_DIAG_EN], 1'b0,
		rep[2]}; // RULE16 RULE17
	assign db[3] = {3'b000, rep[3]};

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		idx_next = idx_reg;
		is_read_next = is_read_reg;
		data_ack_next = data_ack_reg;
		seen_next = seen_reg;
		oe_next = oe_reg;
		ctl1_next = ctl1_reg;
		ctl2_next = ctl2_reg;
		snap_next = snap_reg;
		if (stop_cond) begin
			// partial byte dropped, settings untouched
			state_next = ST_IDLE;
			oe_next = 1'b0;
			seen_next = 1'b0;
		end else if (start_cond) begin
			state_next = ST_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					oe_next = 1'b0;
				end
				ST_ADDR, ST_WR: begin
					if (scl_rise && cnt_reg != BYTE_BITS) begin
						shift_next = {shift_reg[MSB-1:0], sda_sync_reg};
						cnt_next = cnt_reg + 4'h1;
					end else if (byte_done) begin
						cnt_next = 4'h0;
						if (state_reg == ST_ADDR) begin
							if (addr_hit) begin
								oe_next = 1'b1;
								is_read_next = shift_reg[DIR_BIT]; // RULE2
								data_ack_next = 1'b0;
								idx_next = 2'h0;
								state_next = ST_ACK;
								if (shift_reg[DIR_BIT]) begin
									// previous cycle's results frozen
									snap_next = db; // RULE23
									seen_next = 1'b1;
								end
							end else begin
								state_next = ST_IDLE; // RULE1
							end
						end else if (wr_room) begin
							oe_next = 1'b1;
							data_ack_next = 1'b1;
							state_next = ST_ACK;
						end else begin
							state_next = ST_IDLE; // RULE3
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						oe_next = 1'b0;
						if (data_ack_reg) begin
							if (idx_reg == 2'h0)
								ctl1_next = shift_reg; // RULE25
							else
								ctl2_next = shift_reg; // RULE25
							idx_next = idx_reg + 2'h1;
							state_next = ST_WR;
						end else if (is_read_reg) begin
							tx_next = snap_reg[idx_reg]; // RULE4
							oe_next = !snap_reg[idx_reg][MSB];
							cnt_next = 4'h0;
							state_next = ST_RD;
						end else begin
							state_next = ST_WR;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg == LAST_BIT) begin
							oe_next = 1'b0;
							data_ack_next = 1'b0;
							state_next = ST_RD_ACK;
						end else begin
							tx_next = {tx_reg[MSB-1:0], 1'b0};
							oe_next = !tx_reg[MSB-1];
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						if (!sda_sync_reg && !last_rd) begin
							idx_next = idx_reg + 2'h1; // RULE4
							data_ack_next = 1'b1;
						end else begin
							state_next = ST_IDLE;
						end
					end else if (scl_fall && data_ack_reg) begin
						tx_next = snap_reg[idx_reg]; // RULE4
						oe_next = !snap_reg[idx_reg][MSB];
						cnt_next = 4'h0;
						data_ack_next = 1'b0;
						state_next = ST_RD;
					end
				end
				default: begin
					state_next = ST_IDLE;
					oe_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= BYTE_ZERO;
			tx_reg <= BYTE_ZERO;
			idx_reg <= 2'h0;
			is_read_reg <= 1'b0;
			data_ack_reg <= 1'b0;
			seen_reg <= 1'b0;
			oe_reg <= 1'b0;
			restart_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			idx_reg <= idx_next;
			is_read_reg <= is_read_next;
			data_ack_reg <= data_ack_next;
			seen_reg <= seen_next;
			oe_reg <= oe_next;
			restart_reg <= read_done; // RULE23
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ctl1_reg <= CTL1_RESET;
			ctl2_reg <= CTL2_RESET;
			snap_reg <= '{default: BYTE_ZERO};
		end else begin
			ctl1_reg <= ctl1_next;
			ctl2_reg <= ctl2_next;
			snap_reg <= snap_next;
		end
	end

	// open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe_out = oe_reg;
	assign diag_enable_out = ctl1_reg[C1_DIAG_EN]; // RULE5
	assign offset_enable_out = ctl1_reg[C1_OFS_EN]; // RULE6
	assign front_gain_12db_out = ctl1_reg[C1_FRONT_GAIN]; // RULE7
	assign rear_gain_12db_out = ctl1_reg[C1_REAR_GAIN]; // RULE8
	assign front_unmute_out = ctl1_reg[C1_FRONT_UNMUTE]; // RULE9
	assign rear_unmute_out = ctl1_reg[C1_REAR_UNMUTE]; // RULE10
	assign operate_out = ctl2_reg[C2_OPERATE]; // RULE11
	assign line_driver_mode_out = ctl2_reg[C2_LINE_MODE]; // RULE12
	assign test_bits_out = {ctl2_reg[C2_TEST_HI], ctl2_reg[C2_TEST_LO]};
	assign diag_restart_out = restart_reg;

	sequence s_addr_seen;
		(state_reg == ST_ADDR) && byte_done;
	endsequence
	sequence s_read_stop;
		stop_cond && seen_reg;
	endsequence

	property p_foreign_addr;
		@(posedge clock_in) disable iff (rst_in)
		(s_addr_seen and !addr_hit && !stop_cond && !start_cond)
		|=> (state_reg == ST_IDLE) && !sda_oe_out;
	endproperty
	a_foreign_addr: assert property (p_foreign_addr) // RULE1
		else $error("foreign address acknowledged");

	property p_direction;
		@(posedge clock_in) disable iff (rst_in)
		(s_addr_seen and addr_hit && !stop_cond && !start_cond)
		|=> (is_read_reg == $past(shift_reg[DIR_BIT])) && sda_oe_out;
	endproperty
	a_direction: assert property (p_direction) // RULE2
		else $error("direction bit not taken");

	property p_third_byte;
		@(posedge clock_in) disable iff (rst_in)
		((state_reg == ST_WR) && byte_done && (idx_reg == WR_BYTES)
		&& !stop_cond && !start_cond) |=> !sda_oe_out;
	endproperty
	a_third_byte: assert property (p_third_byte) // RULE3
		else $error("extra write byte acknowledged");

	property p_read_order;
		@(posedge clock_in) disable iff (rst_in)
		((state_reg == ST_RD_ACK) && scl_fall && data_ack_reg
		&& !stop_cond && !start_cond)
		|=> (tx_reg == snap_reg[idx_reg]) && (state_reg == ST_RD);
	endproperty
	a_read_order: assert property (p_read_order) // RULE4
		else $error("diagnostic byte out of order");

	property p_commit_one;
		@(posedge clock_in) disable iff (rst_in)
		(commit1 && !stop_cond && !start_cond)
		|=> (diag_enable_out == $past(shift_reg[C1_DIAG_EN]))
		&& (front_unmute_out == $past(shift_reg[C1_FRONT_UNMUTE]));
	endproperty
	a_commit_one: assert property (p_commit_one) // RULE5 RULE9
		else $error("control byte one not applied");

	property p_standby_mirror;
		@(posedge clock_in) disable iff (rst_in)
		(s_addr_seen and addr_hit && shift_reg[DIR_BIT]
		&& !stop_cond && !start_cond)
		|=> snap_reg[2][DB_STANDBY] == operate_out
		&& snap_reg[2][DB_DIAG] == diag_enable_out;
	endproperty
	a_standby_mirror: assert property (p_standby_mirror) // RULE16 RULE17
		else $error("third byte mirror wrong");

	property p_restart;
		@(posedge clock_in) disable iff (rst_in)
		s_read_stop |=> diag_restart_out ##1 !diag_restart_out;
	endproperty
	a_restart: assert property (p_restart) // RULE23
		else $error("read did not restart diagnostics");

	property p_partial;
		@(posedge clock_in) disable iff (rst_in)
		((state_reg == ST_WR) && (stop_cond || start_cond))
		|=> $stable(ctl1_reg) && $stable(ctl2_reg);
	endproperty
	a_partial: assert property (p_partial) // RULE25
		else $error("partial byte changed settings");
endmodule

// ---- bench/adb_host_model.sv ----
// two-wire bus master model standing in for the host processor
// assumes pull-ups on both lines; the bench resolves the wires
`timescale 1ns/100ps
module adb_host_model (
	input wire logic clock_in,
	input wire logic sda_line_in,
	output logic scl_low_out,
	output logic sda_low_out
);
	// both lines released; bus clock stands still between frames
	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	task automatic start_cond();
		tick(4);
		sda_low_out = 1'b1;
		tick(4);
		scl_low_out = 1'b1;
	endtask
	// data only moves while the bus clock is low
	task automatic bit_out(input logic b);
		tick(2);
		sda_low_out = !b;
		tick(2);
		scl_low_out = 1'b0;
		tick(4);
		scl_low_out = 1'b1;
	endtask
	task automatic bit_in(output logic b);
		tick(2);
		sda_low_out = 1'b0;
		tick(2);
		scl_low_out = 1'b0;
		tick(4);
		b = sda_line_in;
		scl_low_out = 1'b1;
	endtask
	task automatic stop_cond();
		tick(2);
		sda_low_out = 1'b1;
		tick(2);
		scl_low_out = 1'b0;
		tick(4);
		sda_low_out = 1'b0;
		tick(8);
	endtask
	// msb first, then the receiver's acknowledge bit
	task automatic send_byte(input logic [7:0] b, output logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		bit_in(ack_n);
	endtask
	task automatic recv_byte(output logic [7:0] b, input logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			bit_in(b[i]);
		end
		bit_out(ack_n);
	endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the amplifier register bank
// assumes the host model owns the bus; fault inputs are driven here
`timescale 1ns/100ps
module tb_top;
	import adb_pkg::*;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic scl_low, sda_low, sda_out, sda_oe_out, ack_n;
	logic thermal = 1'b0, cycle_done = 1'b0;
	logic [3:0] perm = 4'h0, sh_load = 4'h0, open_ld = 4'h0;
	logic [3:0] ofs = 4'h0, sh_vs = 4'h0, sh_gnd = 4'h0;
	logic diag_en, ofs_en, fg, rg, fu, ru, operate, line_mode, restart;
	logic [1:0] test_bits;
	logic [7:0] c1 = 8'h00, c2 = 8'h00, got;
	int fail_count = 0, total_checks = 0, restarts = 0;
	wire scl = !scl_low;
	wire sda = !(sda_low || (sda_oe_out && !sda_out));
	always #10 clock_in = !clock_in;
	// counted mid-cycle, away from the edge that launches the pulse
	always @(negedge clock_in) if (restart) restarts++;
	adb_host_model host_model_inst (.clock_in(clock_in),
		.sda_line_in(sda), .scl_low_out(scl_low), .sda_low_out(sda_low));
	adb_reg_bank adb_reg_bank_inst (.clock_in(clock_in), .rst_in(rst_in),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .thermal_warn_in(thermal),
		.cycle_done_in(cycle_done), .perm_diag_in(perm),
		.short_load_in(sh_load), .open_load_in(open_ld), .offset_in(ofs),
		.short_vs_in(sh_vs), .short_gnd_in(sh_gnd),
		.diag_enable_out(diag_en), .offset_enable_out(ofs_en),
		.front_gain_12db_out(fg), .rear_gain_12db_out(rg),
		.front_unmute_out(fu), .rear_unmute_out(ru),
		.operate_out(operate), .line_driver_mode_out(line_mode),
		.test_bits_out(test_bits), .diag_restart_out(restart));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chk_ctl();
		check("control one", {1'b0, diag_en, ofs_en, fg, rg, fu, ru, 1'b0},
			c1 & 8'h7E);
		check("control two", {1'b0, test_bits, operate, line_mode, 3'b000},
			c2 & 8'h78);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] b1,
		input logic [7:0] b2, input int n);
		logic [7:0] data [3];
		data = '{b1, b2, 8'hFF};
		host_model_inst.start_cond();
		host_model_inst.send_byte(a, ack_n);
		check("write address ack", {7'h00, ack_n},
			{7'h00, a[7:1] != CHIP_ADDR});
		for (int k = 0; k < n && !ack_n; k++) begin
			host_model_inst.send_byte(data[k], ack_n);
			check("data ack", {7'h00, ack_n}, {7'h00, k == 2});
			if (k == 0) c1 = b1;
			if (k == 1) c2 = b2;
		end
		host_model_inst.stop_cond();
	endtask
	task automatic rd(input logic [3:0] d2, input logic flip);
		logic [7:0] exp [4];
		int r0;
		r0 = restarts;
		for (int ch = 0; ch < 4; ch++) begin
			exp[ch] = {3'b000, perm[ch], sh_load[ch], d2[ch], sh_vs[ch],
				sh_gnd[ch]};
		end
		exp[0][7:6] = {thermal, cycle_done};
		exp[1][7] = c1[C1_OFS_EN];
		exp[2][7:6] = {c2[C2_OPERATE], c1[C1_DIAG_EN]};
		host_model_inst.start_cond();
		host_model_inst.send_byte({CHIP_ADDR, 1'b1}, ack_n);
		check("read address ack", {7'h00, ack_n}, 8'h00);
		for (int k = 0; k < 4; k++) begin
			host_model_inst.recv_byte(got, k == 3);
			check("diag byte", got, exp[k]);
			if (flip && k == 0) sh_gnd = ~sh_gnd;
		end
		host_model_inst.stop_cond();
		check("restart pulses", 8'(restarts - r0), 8'h01);
	endtask
	initial begin
		repeat (20000) @(posedge clock_in);
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (2) @(negedge clock_in);
		rst_in = 1'b0;
		repeat (3) @(negedge clock_in);
		check("sda enable", {7'h00, sda_oe_out}, 8'h00);
		chk_ctl();
		$display("test reset done");
		wr(8'hD8, 8'h54, 8'h28, 2);
		chk_ctl();
		wr(8'hD8, 8'h2A, 8'h50, 2);
		chk_ctl();
		check("restart on write", 8'(restarts), 8'h00);
		$display("test write done");
		wr(8'hDA, 8'h54, 8'h28, 1);
		chk_ctl();
		wr(8'hD8, 8'h7E, 8'h00, 1);
		chk_ctl();
		wr(8'hD8, 8'h54, 8'h18, 3);
		chk_ctl();
		host_model_inst.start_cond();
		host_model_inst.send_byte(8'hD8, ack_n);
		for (int i = 0; i < 4; i++) begin
			host_model_inst.bit_out(1'b0);
		end
		host_model_inst.stop_cond();
		chk_ctl();
		$display("test refuse done");
		thermal = 1'b1;
		cycle_done = 1'b1;
		sh_load = 4'h1;
		open_ld = 4'h2;
		sh_vs = 4'h4;
		sh_gnd = 4'h8;
		rd(open_ld, 1'b1);
		thermal = 1'b0;
		cycle_done = 1'b0;
		perm = 4'hA;
		rd(4'h0, 1'b0);
		$display("test read done");
		ofs = 4'h5;
		wr(8'hD8, 8'h74, 8'h18, 2);
		rd(4'h5, 1'b0);
		ofs = 4'h4;
		repeat (20) @(negedge clock_in);
		ofs = 4'h5;
		rd(4'h4, 1'b0);
		$display("test offset done");
		complete_run();
	end
endmodule
